/* File: design/emulator_event_trigger_control.v */
// What this block does
// - An open-marker address match makes the hardware event active.
// - A close-marker address match makes the active event inactive.
// - Single-hit event is asserted only in cycles accessing its address.
// - With filtering on, trace recording follows the trigger events; else ungated.
// - Break on trace overflow stops the program when the buffer is full.
// - Break on trigger input stops on rising edge after current instruction.
// - Trigger output follows selected mode: open/close pair or single hit.
// - Halt-reset option: halt with watchdog enabled resets the chip.
// - No-reset option: halt with watchdog enabled causes no reset.
// - First mapping: level zero from port A, level one from B and C.
// - Watchdog start is by software (held until reset) or by the hardware option bit while it is set.
// - Low-voltage detect honoured only at 5 V, threshold 4.3 V.
// - Clock filter option enables the filter, otherwise bypassed.
// - Clock source on-board or external; on-chip only for first group.
`include "event_trigger_consts.vh"
module emulator_event_trigger_control (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire access_valid,
  input wire [15:0] access_addr,
  input wire insn_done,
  input wire trace_full,
  input wire trigger_input,
  input wire halt_exec,
  input wire wdg_sw_start,
  input wire [7:0] port_a_irq,
  input wire [7:0] port_b_irq,
  input wire [5:0] port_c_irq,
  input wire lvd_request,
  output reg trigger_output,
  output reg trace_record,
  output reg program_stop,
  output reg chip_reset,
  output reg ext_irq_level_zero,
  output reg ext_irq_level_one,
  output reg watchdog_enable,
  output reg low_voltage_detect,
  output reg [15:0] lvd_threshold_mv,
  output reg clock_filter_en,
  output reg [1:0] clock_source,
  output reg irq
);
  ////////////////////////////////////////////////////////////////
  reg [4:0] ctrl;
  reg [8:0] opts;
  reg [15:0] event_open_marker;
  reg [15:0] event_close_marker;
  reg [15:0] event_single_hit;
  reg [3:0] status;
  reg [3:0] irq_en;
  reg event_active;
  reg trig_in_q;
  reg stop_pending;
  reg wdg_hw_started;
  wire wr;
  wire rd;
  wire open_hit;
  wire close_hit;
  wire single_hit;
  wire event_now;
  wire trig_rise;
  wire ovf_brk;
  wire halt_rst;
  wire [3:0] evt;
  wire [3:0] clr;
  wire [1:0] clk_req;
  reg [31:0] next_rdata;
  reg next_err;

  assign wr = psel & penable & pwrite & ~pready;
  assign rd = psel & penable & ~pwrite & ~pready;
  assign open_hit = access_valid & (access_addr == event_open_marker);
  assign close_hit = access_valid & (access_addr == event_close_marker);
  assign single_hit = access_valid & (access_addr == event_single_hit);
  // Pair event is visible in the open cycle and drops in the close cycle.
  assign event_now = ctrl[`CTRL_MODE_HIT] ? single_hit :
                     ((event_active | open_hit) & ~close_hit);
  assign trig_rise = trigger_input & ~trig_in_q;
  assign ovf_brk = ctrl[`CTRL_BRK_OVF] & trace_full;
  assign halt_rst = halt_exec & watchdog_enable & opts[`OPT_HALT_RESET];
  assign evt = {halt_rst, trig_rise & ctrl[`CTRL_BRK_TRIG], ovf_brk, event_now};
  assign clr = (wr && paddr == `REG_IRQ_CLR) ? pwdata[3:0] : 4'h0;
  assign clk_req = opts[`OPT_CLK_SEL_HI:`OPT_CLK_SEL_LO];

  ////////////////////////////////////////////////////////////////
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `REG_CTRL: next_rdata = {27'h0, ctrl};
      `REG_OPTS: next_rdata = {23'h0, opts};
      `REG_OPEN: next_rdata = {16'h0, event_open_marker};
      `REG_CLOSE: next_rdata = {16'h0, event_close_marker};
      `REG_HIT: next_rdata = {16'h0, event_single_hit};
      `REG_STATUS: next_rdata = {28'h0, status};
      `REG_IRQ_EN: next_rdata = {28'h0, irq_en};
      `REG_IRQ_CLR: next_rdata = 32'h0000_0000;
      `REG_TRACE: next_rdata = {29'h0, program_stop, event_active, trace_record};
      default: next_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      opts <= `OPTS_RESET;
      event_open_marker <= 16'h0000;
      event_close_marker <= 16'h0000;
      event_single_hit <= 16'h0000;
      status <= 4'h0;
      irq_en <= 4'h0;
      event_active <= 1'b0;
      trig_in_q <= 1'b0;
      stop_pending <= 1'b0;
      wdg_hw_started <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      trigger_output <= 1'b0;
      trace_record <= 1'b0;
      program_stop <= 1'b0;
      chip_reset <= 1'b0;
      ext_irq_level_zero <= 1'b0;
      ext_irq_level_one <= 1'b0;
      watchdog_enable <= 1'b0;
      low_voltage_detect <= 1'b0;
      lvd_threshold_mv <= 16'h0000;
      clock_filter_en <= 1'b0;
      clock_source <= `CLK_ONBOARD;
      irq <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (rd) begin
        prdata <= next_rdata;
        pslverr <= next_err;
      end
      if (wr) begin
        pslverr <= next_err;
        case (paddr)
          `REG_CTRL: ctrl <= pwdata[4:0];
          `REG_OPTS: opts <= pwdata[8:0];
          `REG_OPEN: event_open_marker <= pwdata[15:0];
          `REG_CLOSE: event_close_marker <= pwdata[15:0];
          `REG_HIT: event_single_hit <= pwdata[15:0];
          `REG_IRQ_EN: irq_en <= pwdata[3:0];
          default: ctrl <= ctrl;
        endcase
      end
      // Resume is a self-clearing command bit.
      if (ctrl[`CTRL_RESUME])
        ctrl[`CTRL_RESUME] <= 1'b0;
      // Event sets win over a clear in the same cycle.
      status <= (status & ~clr) | evt;
      irq <= |(((status & ~clr) | evt) & irq_en);
      if (open_hit & ~close_hit)
        event_active <= 1'b1;
      else if (close_hit)
        event_active <= 1'b0;
      trig_in_q <= trigger_input;
      trigger_output <= event_now;
      trace_record <= ctrl[`CTRL_FILTER] ? event_now : 1'b1;
      if (trig_rise & ctrl[`CTRL_BRK_TRIG])
        stop_pending <= 1'b1;
      if (ovf_brk | (insn_done & (stop_pending | (trig_rise & ctrl[`CTRL_BRK_TRIG])))) begin
        program_stop <= 1'b1;
        stop_pending <= 1'b0;
      end else if (ctrl[`CTRL_RESUME]) begin
        program_stop <= 1'b0;
      end
      chip_reset <= halt_rst | (lvd_request & low_voltage_detect);
      if (opts[`OPT_IRQ_MAP]) begin
        ext_irq_level_zero <= (|port_a_irq) | (|port_c_irq);
        ext_irq_level_one <= |port_b_irq;
      end else begin
        ext_irq_level_zero <= |port_a_irq;
        ext_irq_level_one <= (|port_b_irq) | (|port_c_irq);
      end
      if (wdg_sw_start)
        wdg_hw_started <= 1'b1;
      watchdog_enable <= opts[`OPT_WDG_HW] | wdg_hw_started;
      low_voltage_detect <= opts[`OPT_LVD_EN] & opts[`OPT_VDD_5V];
      lvd_threshold_mv <= `LVD_THRESH_MV;
      clock_filter_en <= opts[`OPT_CLK_FILT];
      if (clk_req == `CLK_ONCHIP && !opts[`OPT_GROUP_ONE])
        clock_source <= `CLK_ONBOARD;
      else if (clk_req == `CLK_ONCHIP || clk_req == `CLK_EXTERNAL)
        clock_source <= clk_req;
      else
        clock_source <= `CLK_ONBOARD;
    end
  end
endmodule

/* File: include/event_trigger_consts.vh */
`ifndef EVENT_TRIGGER_CONSTS_VH
`define EVENT_TRIGGER_CONSTS_VH
`define ADDR_W 16
`define REG_CTRL 12'h000
`define REG_OPTS 12'h004
`define REG_OPEN 12'h008
`define REG_CLOSE 12'h00C
`define REG_HIT 12'h010
`define REG_STATUS 12'h014
`define REG_IRQ_EN 12'h018
`define REG_IRQ_CLR 12'h01C
`define REG_TRACE 12'h020
`define CTRL_MODE_HIT 0
`define CTRL_FILTER 1
`define CTRL_BRK_OVF 2
`define CTRL_BRK_TRIG 3
`define CTRL_RESUME 4
`define OPT_HALT_RESET 0
`define OPT_WDG_HW 1
`define OPT_VDD_5V 2
`define OPT_LVD_EN 3
`define OPT_CLK_FILT 4
`define OPT_IRQ_MAP 5
`define OPT_CLK_SEL_LO 6
`define OPT_CLK_SEL_HI 7
`define OPT_GROUP_ONE 8
`define CLK_ONBOARD 2'h0
`define CLK_EXTERNAL 2'h1
`define CLK_ONCHIP 2'h2
`define ST_TRIG 0
`define ST_OVF_BRK 1
`define ST_TRIG_BRK 2
`define ST_HALT_RST 3
`define NUM_EVT 4
`define CTRL_RESET 5'h00
`define OPTS_RESET 9'h000
`define LVD_THRESH_MV 16'h10CC
`endif

/* File: verif/event_trigger_assertions.sv */
`include "event_trigger_consts.vh"
module event_trigger_checker (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire access_valid,
  input wire insn_done,
  input wire trace_full,
  input wire halt_exec,
  input wire wdg_sw_start,
  input wire lvd_request,
  input wire trigger_output,
  input wire program_stop,
  input wire chip_reset,
  input wire watchdog_enable,
  input wire low_voltage_detect,
  input wire [15:0] lvd_threshold_mv
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access; psel && penable && !pready && clk_en; endsequence
  property p_ready; s_access |=> pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_event; $rose(trigger_output) |-> $past(access_valid); endproperty
  property p_stop; $rose(program_stop) |-> $past(trace_full || insn_done); endproperty
  property p_hold; program_stop && !psel && !$past(psel) |=> program_stop; endproperty
  property p_wdg; wdg_sw_start && clk_en |-> ##2 watchdog_enable; endproperty
  property p_lvd;
    lvd_request && low_voltage_detect && clk_en |=> chip_reset && lvd_threshold_mv == `LVD_THRESH_MV;
  endproperty
  property p_halt;
    $rose(chip_reset) |-> $past(halt_exec && watchdog_enable) || $past(lvd_request && low_voltage_detect);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after access");
  a_err: assert property (p_err) else $error("error without ready");
  a_event: assert property (p_event) else $error("event without access");
  a_stop: assert property (p_stop) else $error("stop without cause");
  a_hold: assert property (p_hold) else $error("stop dropped");
  a_wdg: assert property (p_wdg) else $error("watchdog not started");
  a_lvd: assert property (p_lvd) else $error("bad voltage detect");
  a_halt: assert property (p_halt) else $error("reset without halt");
endmodule
bind emulator_event_trigger_control event_trigger_checker u_chk (.*);

/* File: verif/insn_pacer.sv */
module insn_pacer (
  input wire pclk,
  output logic insn_done = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Paces instruction ends as the emulated CPU would on a supplied clock.
  logic [1:0] phase = 2'h0;
  always @(posedge pclk) begin
    phase <= phase + 2'h1;
    insn_done <= (phase == 2'h3);
  end
endmodule

/* File: verif/tb_emulator_event_trigger_control.sv */
`include "event_trigger_consts.vh"
module tb_emulator_event_trigger_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic access_valid = 1'b0, trace_full = 1'b0, trigger_input = 1'b0, halt_exec = 1'b0;
  logic wdg_sw_start = 1'b0, lvd_request = 1'b0, insn_done, trigger_output, trace_record;
  logic program_stop, chip_reset, ext_irq_level_zero, ext_irq_level_one, watchdog_enable;
  logic low_voltage_detect, clock_filter_en, irq, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [15:0] access_addr = 16'h0000, lvd_threshold_mv;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [5:0] port_c_irq = 6'h00;
  logic [7:0] port_a_irq = 8'h00, port_b_irq = 8'h00;
  logic [1:0] clock_source;
  int n_errors = 0, n_checks = 0, cyc = 0;
  always #2 pclk = ~pclk;
  emulator_event_trigger_control uut (.*, .clk_en(1'b1));
  insn_pacer pacer (.pclk(pclk), .insn_done(insn_done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic acc(input logic [15:0] a);
    @(posedge pclk);
    access_valid <= 1'b1;
    access_addr <= a;
    @(posedge pclk);
    access_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic halt();
    @(posedge pclk);
    halt_exec <= 1'b1;
    wdg_sw_start <= 1'b0;
    @(posedge pclk);
    halt_exec <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("record", 1, trace_record);
    apb(1'b0, `REG_OPTS, 0);
    chk("opts", `OPTS_RESET, q);
    apb(1'b0, 12'h030, 0);
    chk("slverr", 1, e);
    apb(1'b1, `REG_OPEN, 32'h1234);
    apb(1'b1, `REG_CLOSE, 32'h2000);
    apb(1'b1, `REG_IRQ_EN, 1);
    acc(16'h1234);
    chk("irq", 1, irq);
    acc(16'h0100);
    chk("open", 1, trigger_output);
    acc(16'h2000);
    chk("close", 0, trigger_output);
    apb(1'b1, `REG_IRQ_EN, 0);
    @(posedge pclk);
    chk("masked", 0, irq);
    apb(1'b1, `REG_IRQ_CLR, 1);
    apb(1'b1, `REG_IRQ_EN, 1);
    @(posedge pclk);
    chk("cleared", 0, irq);
    apb(1'b1, `REG_HIT, 32'h0300);
    apb(1'b1, `REG_CTRL, 1);
    acc(16'h0300);
    chk("hit", 1, trigger_output);
    @(posedge pclk);
    chk("hit end", 0, trigger_output);
    apb(1'b1, `REG_CTRL, 32'h6);
    trace_full <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("filter", 0, trace_record);
    chk("ovf stop", 1, program_stop);
    trace_full <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'h18);
    repeat (2) @(posedge pclk);
    chk("resume", 0, program_stop);
    trigger_input <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("trig stop", 1, program_stop);
    $display("test events done");
    apb(1'b1, `REG_OPTS, 32'h19F);
    lvd_request <= 1'b1;
    halt();
    chk("reset", 1, chip_reset);
    chk("wdg hw", 1, watchdog_enable);
    chk("lvd", 1, low_voltage_detect);
    chk("thresh", 16'h10CC, lvd_threshold_mv);
    chk("filt", 1, clock_filter_en);
    chk("src", `CLK_ONCHIP, clock_source);
    wdg_sw_start <= 1'b1;
    apb(1'b1, `REG_OPTS, 32'h080);
    port_c_irq <= 6'h01;
    halt();
    chk("no reset", 0, chip_reset);
    chk("wdg sw", 1, watchdog_enable);
    chk("lvd off", 0, low_voltage_detect);
    chk("filt off", 0, clock_filter_en);
    chk("src back", `CLK_ONBOARD, clock_source);
    chk("map0 one", 1, ext_irq_level_one);
    apb(1'b1, `REG_OPTS, 32'h0A0);
    repeat (2) @(posedge pclk);
    chk("map1 zero", 1, ext_irq_level_zero);
    chk("map1 one", 0, ext_irq_level_one);
    port_c_irq <= 6'h00;
    port_b_irq <= 8'h01;
    repeat (2) @(posedge pclk);
    chk("map1 b one", 1, ext_irq_level_one);
    chk("map1 b zero", 0, ext_irq_level_zero);
    port_b_irq <= 8'h00;
    port_a_irq <= 8'h01;
    repeat (2) @(posedge pclk);
    chk("map1 a zero", 1, ext_irq_level_zero);
    $display("test options done");
    complete_run();
  end
endmodule
